// ### seep_top.sv
// Serial EEPROM command logic (SPI slave mode 0) with protect levels and a page FIFO.
// Assumes chip select, serial clock, data in and protect pin come from another domain.
`timescale 1ns/1ns

// ****************************************************************
// Small FIFO with parameters for width and depth
// ****************************************************************
module seep_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 4
) (
	input  wire logic             clock,     // System clock.
	input  wire logic             reset,     // Synchronous reset.
	input  wire logic             flush,     // Empties the FIFO.
	input  wire logic             in_valid,  // Write strobe.
	output logic                  in_ready,  // Not full.
	input  wire logic [WIDTH-1:0] in_data,   // Word in.
	output logic                  out_valid, // Not empty.
	input  wire logic             out_ready, // Read strobe.
	output logic [WIDTH-1:0]      out_data   // Word out.
);
	logic [WIDTH-1:0]         mem [DEPTH];
	logic [$clog2(DEPTH):0]   count_reg;
	logic [$clog2(DEPTH)-1:0] wp_reg;
	logic [$clog2(DEPTH)-1:0] rp_reg;
	logic                     push;
	logic                     pop;

	// Honest flags straight from the count.
	assign in_ready = count_reg != DEPTH[$clog2(DEPTH):0];
	assign out_valid = count_reg != '0;
	assign out_data = mem[rp_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and count update.
	always_ff @(posedge clock) begin
		if (reset || flush) begin
			wp_reg <= '0;
			rp_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				mem[wp_reg] <= in_data;
				wp_reg <= wp_reg + 1'b1;
			end
			if (pop)
				rp_reg <= rp_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// Overview of operation
// (RULE_01) Array is four equal segments; selected protected segments are read only.
// (RULE_02) Protect bits: 00 none, 01 top quarter, 10 top half, 11 all.
// (RULE_03) Protect and pin-enable bits persist and change only by timed write.
// (RULE_04) Hardware protection only while protect pin low and pin-enable bit set.
// (RULE_05) Pin high or enable clear: status writes accepted when write enabled.
// (RULE_06) Hardware protected: refuse status writes and protected areas; others proceed.
// (RULE_07) Enabled bit with pin low cannot return to zero until pin high.
// (RULE_08) Without write enable nothing at all is writable.
// (RULE_09) Read: opcode, 16-bit address, then byte out MSB first.
// (RULE_10) Continued clocking increments the address, wrapping to zero.
// (RULE_11) Master raises select after eight bits for a single byte.
// (RULE_12) Write: opcode, address, data; programming begins when select rises.
// (RULE_13) Master raises select in clock low time after last data bit.
// (RULE_14) Master targets unprotected addresses; device never programs protected ones.
// (RULE_15) While programming, every instruction except status read is ignored.
// (RULE_16) Status bit 0 is one while programming, zero when done.
// (RULE_17) Page write increments only low five address bits, wrapping in page.
// (RULE_18) Write enable clears when a programming cycle ends.
// (RULE_19) Write without enable is discarded until a new select fall.
// (RULE_20) Opcodes decoded with bit 3 ignored.
// (RULE_21) Status byte: pin-enable 7, protect 3:2, write enable 1, busy 0.
// (RULE_22) Status bits 6:4 zero when idle; whole byte ones while busy.
// (RULE_23) Unknown opcode: nothing accepted, output off until next select fall.
// (RULE_24) Address bits above the array size are ignored.
// (RULE_25) Programming time is a parameter; busy holds until the timer ends.
// (RULE_26) Nonvolatile bits load at power-up; write enable starts cleared.
module seep_top #(
	parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES  // Programming time in cycles.
) (
	input  wire logic       clock,        // 20 MHz system clock.
	input  wire logic       reset,        // Synchronous reset, active high.
	input  wire logic       cs_n,         // Chip select pin, active low.
	input  wire logic       sck,          // Serial clock pin.
	input  wire logic       si,           // Serial data in pin.
	input  wire logic       wp_n,         // Write protect pin, active low.
	input  wire logic [2:0] nv_status_in, // Stored pin-enable and protect bits.
	output logic            so,           // Serial data out.
	output logic            so_oe,        // High while driving serial out.
	output logic            busy,         // Programming in progress.
	output logic [2:0]      nv_status_out // Current pin-enable and protect bits.
);
	typedef enum logic [2:0] {
		CMD, ADDR_HI, ADDR_LO, RD_DATA, WR_DATA, ST_OUT, ST_IN, DEAD
	} seep_state_t;

	logic [7:0]  mem [seep_pkg::DEPTH];
	logic [2:0]  cs_s, sck_s;
	logic [1:0]  si_s, wp_s;
	seep_state_t state_reg;
	logic [2:0]  bit_reg;
	logic [7:0]  sh_reg;
	logic [7:0]  out_reg;
	logic [12:0] addr_reg;
	logic        wen_reg;
	logic        pen_reg;
	logic [1:0]  bp_reg;
	logic        st_pend_reg;
	logic [2:0]  st_new_reg;
	logic        wr_pend_reg;
	logic        busy_reg;
	logic [31:0] timer_reg;
	logic        so_reg, so_oe_reg, rd_op_reg, boot_reg;
	logic        sck_rise, sck_fall, cs_rise, cs_fall, selected, byte_done;
	logic [7:0]  rx_byte, opc;
	logic        hw_prot;
	logic [7:0]  st_idle;
	seep_pkg::seep_wr_t fifo_in, fifo_out;
	logic        fifo_in_ready, fifo_out_valid, fifo_push, fifo_pop;

	// True when an address lies inside the selected protected segments.
	function automatic logic is_prot(input logic [1:0] bp, input logic [12:0] a);
		case (bp)
			seep_pkg::BP_NONE:    is_prot = 1'b0;
			seep_pkg::BP_QUARTER: is_prot = a >= seep_pkg::QUARTER_BASE; // see (RULE_02)
			seep_pkg::BP_HALF:    is_prot = a >= seep_pkg::HALF_BASE;
			default:              is_prot = 1'b1;
		endcase
	endfunction

	// ****************************************************************
	// Pin synchronisers and edge finding
	// ****************************************************************
	// First stage is read only by the second; edges use stages two and three.
	always_ff @(posedge clock) begin
		cs_s <= {cs_s[1:0], cs_n};
		sck_s <= {sck_s[1:0], sck};
		si_s <= {si_s[0], si};
		wp_s <= {wp_s[0], wp_n};
	end

	assign sck_rise = sck_s[2:1] == 2'b01 && !cs_s[1];
	assign sck_fall = sck_s[2:1] == 2'b10 && !cs_s[1];
	assign cs_rise = cs_s[2:1] == 2'b01;
	assign cs_fall = cs_s[2:1] == 2'b10;
	assign selected = !cs_s[1];
	assign rx_byte = {sh_reg[6:0], si_s[1]};
	assign byte_done = sck_rise && bit_reg == 3'h7;
	assign opc = rx_byte & seep_pkg::OPC_MASK; // see (RULE_20)
	assign hw_prot = !wp_s[1] && pen_reg; // see (RULE_04)

	// ****************************************************************
	// Command sequencer
	// ****************************************************************
	// Bits are taken on serial clock rise; data out changes on the fall (mode 0).
	always_ff @(posedge clock) begin
		if (reset || cs_fall || !selected) begin
			state_reg <= CMD;
			bit_reg <= '0;
		end else if (sck_rise) begin
			bit_reg <= bit_reg + 1'b1;
			sh_reg <= rx_byte;
			if (byte_done) begin
				case (state_reg)
					CMD: begin
						if (busy_reg && opc != seep_pkg::OPC_STATUS_READ_CMD)
							state_reg <= DEAD; // see (RULE_15)
						else case (opc)
							seep_pkg::OPC_READ:  state_reg <= ADDR_HI; // see (RULE_09)
							seep_pkg::OPC_WRITE: state_reg <= wen_reg ? ADDR_HI : DEAD; // see (RULE_19)
							seep_pkg::OPC_STATUS_READ_CMD:  state_reg <= ST_OUT;
							seep_pkg::OPC_STATUS_WRITE_CMD:  state_reg <= wen_reg ? ST_IN : DEAD; // see (RULE_08)
							seep_pkg::OPC_WRITE_ENABLE_CMD, seep_pkg::OPC_WRITE_DISABLE_CMD: state_reg <= DEAD;
							default:             state_reg <= DEAD; // see (RULE_23)
						endcase
						rd_op_reg <= opc == seep_pkg::OPC_READ;
					end
					ADDR_HI: begin
						addr_reg[12:8] <= rx_byte[4:0]; // see (RULE_24)
						state_reg <= ADDR_LO;
					end
					ADDR_LO: begin
						addr_reg[7:0] <= rx_byte;
						state_reg <= rd_op_reg ? RD_DATA : WR_DATA;
					end
					RD_DATA: addr_reg <= addr_reg + 1'b1; // see (RULE_10)
					WR_DATA: addr_reg[4:0] <= addr_reg[4:0] + 1'b1; // see (RULE_17)
					ST_IN:   state_reg <= DEAD;
					ST_OUT:  state_reg <= ST_OUT;
					default: state_reg <= DEAD;
				endcase
			end
		end
	end

	// ****************************************************************
	// Serial output
	// ****************************************************************
	// Output byte loads when the first data bit is due, then shifts on falls.
	always_ff @(posedge clock) begin
		if (reset || !selected) begin
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
			out_reg <= '0;
		end else if (sck_fall) begin
			if (state_reg == RD_DATA || state_reg == ST_OUT) begin
				if (bit_reg == 3'h0) begin
					if (state_reg == RD_DATA)
						out_reg <= {mem[addr_reg][6:0], 1'b0}; // see (RULE_09)
					else if (busy_reg)
						out_reg <= {seep_pkg::ST_BUSY_VAL[6:0], 1'b0}; // see (RULE_22)
					else
						out_reg <= {st_idle[6:0], 1'b0}; // see (RULE_21)
					so_reg <= state_reg == RD_DATA ? mem[addr_reg][7] :
						(busy_reg ? 1'b1 : st_idle[7]);
				end else begin
					so_reg <= out_reg[7];
					out_reg <= {out_reg[6:0], 1'b0};
				end
				so_oe_reg <= 1'b1;
			end else
				so_oe_reg <= 1'b0; // see (RULE_23)
		end
	end

	// Idle status image; bit 7 goes out first and the rest shift out of out_reg.
	assign st_idle = {pen_reg, 3'h0, bp_reg, wen_reg, busy_reg}; // see (RULE_21)

	// ****************************************************************
	// Write path: page FIFO in front of the array
	// ****************************************************************
	// A refused byte simply never enters the FIFO, so protected cells never change.
	assign fifo_in = '{addr: addr_reg, data: rx_byte};
	assign fifo_push = byte_done && state_reg == WR_DATA && selected && fifo_in_ready
		&& !is_prot(bp_reg, addr_reg); // see (RULE_14)
	// The whole page drains once select rises, before the next frame can flush it.
	assign fifo_pop = fifo_out_valid && !selected;

	seep_fifo #(
		.WIDTH($bits(seep_pkg::seep_wr_t)),
		.DEPTH(seep_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.reset(reset),
		.flush(cs_fall),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	// Array is written only after select rises; a deeper page drops excess bytes.
	always_ff @(posedge clock) begin
		if (fifo_pop)
			mem[fifo_out.addr] <= fifo_out.data; // see (RULE_12)
	end

	// ****************************************************************
	// Status bits, write enable and programming timer
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			wen_reg <= 1'b0; // see (RULE_26)
			st_pend_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			busy_reg <= 1'b0;
			timer_reg <= '0;
			pen_reg <= 1'b0;
			bp_reg <= seep_pkg::BP_NONE;
			st_new_reg <= '0;
		end else begin
			// The stored protect image is taken once, in the first cycle after reset.
			if (boot_reg) begin
				pen_reg <= nv_status_in[2]; // see (RULE_26)
				bp_reg <= nv_status_in[1:0];
			end
			if (state_reg == CMD && byte_done && !busy_reg && opc == seep_pkg::OPC_WRITE_ENABLE_CMD)
				wen_reg <= 1'b1;
			if (state_reg == CMD && byte_done && !busy_reg && opc == seep_pkg::OPC_WRITE_DISABLE_CMD)
				wen_reg <= 1'b0;
			// Status write is taken on its eighth bit only if not hardware protected.
			if (state_reg == ST_IN && byte_done && !hw_prot) begin // see (RULE_06)
				st_pend_reg <= 1'b1; // see (RULE_05)
				st_new_reg <= {rx_byte[seep_pkg::ST_PEN], rx_byte[seep_pkg::ST_BP_HI],
					rx_byte[seep_pkg::ST_BP_LO]};
			end
			if (state_reg == WR_DATA && byte_done && fifo_push)
				wr_pend_reg <= 1'b1;
			if (cs_fall) begin
				st_pend_reg <= 1'b0;
				wr_pend_reg <= 1'b0;
			end
			// Protect pin falling before select rises cancels a pending status write while the pin-enable bit is set.
			if (cs_rise && (wr_pend_reg || (st_pend_reg && !hw_prot))) begin // see (RULE_07)
				busy_reg <= 1'b1; // see (RULE_12)
				timer_reg <= 32'(PROG_CYCLES);
				if (st_pend_reg) begin
					pen_reg <= st_new_reg[2]; // see (RULE_03)
					bp_reg <= st_new_reg[1:0];
				end
				st_pend_reg <= 1'b0;
				wr_pend_reg <= 1'b0;
			end else if (busy_reg) begin
				if (timer_reg == 32'h1) begin
					busy_reg <= 1'b0; // see (RULE_25)
					wen_reg <= 1'b0; // see (RULE_18)
				end
				timer_reg <= timer_reg - 32'h1;
			end
		end
	end

	// Marks the first cycle after reset, when the stored bits are loaded.
	always_ff @(posedge clock) begin
		if (reset)
			boot_reg <= 1'b1;
		else
			boot_reg <= 1'b0;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			so <= 1'b0;
			so_oe <= 1'b0;
			busy <= 1'b0;
			nv_status_out <= '0;
		end else begin
			so <= so_reg;
			so_oe <= so_oe_reg;
			busy <= busy_reg; // see (RULE_16)
			nv_status_out <= boot_reg ? nv_status_in : {pen_reg, bp_reg};
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence start_prog_s;
		cs_rise && (wr_pend_reg || (st_pend_reg && !hw_prot));
	endsequence

	property prog_start_p;
		@(posedge clock) disable iff (reset) start_prog_s |=> busy_reg;
	endproperty

	prog_start_a: assert property (prog_start_p) // see (RULE_12)
		else $error("Programming did not start at select rise.");

	no_prot_write_a: assert property (@(posedge clock) disable iff (reset) // see (RULE_01)
		fifo_pop |-> !is_prot(bp_reg, fifo_out.addr))
		else $error("Protected address reached the array.");

	page_wrap_a: assert property (@(posedge clock) disable iff (reset) // see (RULE_17)
		(state_reg == WR_DATA && byte_done && selected) |=>
		addr_reg[12:5] == $past(addr_reg[12:5]))
		else $error("Page write changed the upper address bits.");

	wen_clear_a: assert property (@(posedge clock) disable iff (reset) // see (RULE_18)
		$fell(busy_reg) |-> !wen_reg)
		else $error("Write enable survived the end of programming.");

	hw_lock_a: assert property (@(posedge clock) disable iff (reset) // see (RULE_07)
		(pen_reg && !wp_s[1] && !busy_reg) |=> pen_reg)
		else $error("Pin-enable bit cleared while protect pin low.");

	busy_cmd_a: assert property (@(posedge clock) disable iff (reset) // see (RULE_15)
		(busy_reg && state_reg == CMD && byte_done && opc != seep_pkg::OPC_STATUS_READ_CMD)
		|=> state_reg == DEAD || !selected)
		else $error("Command taken while programming.");

	no_wen_a: assert property (@(posedge clock) disable iff (reset) // see (RULE_08)
		(state_reg == CMD && byte_done && !wen_reg && !busy_reg &&
		opc == seep_pkg::OPC_WRITE) |=> state_reg == DEAD || !selected)
		else $error("Write accepted without write enable.");

	busy_out_a: assert property (@(posedge clock) disable iff (reset) // see (RULE_16)
		busy_reg |=> busy)
		else $error("Busy output does not follow programming.");

	st_idle_a: assert property (@(posedge clock) disable iff (reset) // see (RULE_22)
		(sck_fall && state_reg == ST_OUT && bit_reg == 3'h0 && !busy_reg) |=>
		out_reg[7:5] == 3'h0)
		else $error("Idle status upper bits not zero.");
endmodule

// ### seep_pkg.sv
// Package with the constants and carrier types of the serial EEPROM command block.
// Assumes a 20 MHz system clock; the SPI clock is sampled as an ordinary input.
package seep_pkg;
	// ****************************************************************
	// Array geometry
	// ****************************************************************
	localparam int ADDR_BITS = 13;
	localparam int DEPTH = 8192;
	localparam int PAGE_BITS = 5;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_ALL = 2'h3;
	localparam logic [12:0] QUARTER_BASE = 13'h1800;
	localparam logic [12:0] HALF_BASE = 13'h1000;
	// ****************************************************************
	// Opcodes, bit 3 masked off before compare
	// ****************************************************************
	localparam logic [7:0] OPC_MASK = 8'hF7;
	localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] OPC_STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_WRITE = 8'h02;
	// ****************************************************************
	// Status byte fields
	// ****************************************************************
	localparam int ST_PEN = 7;
	localparam int ST_BP_HI = 3;
	localparam int ST_BP_LO = 2;
	localparam int ST_WEN = 1;
	localparam int ST_BUSY = 0;
	localparam logic [7:0] ST_BUSY_VAL = 8'hFF;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 20000000;
	localparam int PROG_MS = 5;
	localparam int PROG_CYCLES = CLK_HZ / 1000 * PROG_MS;
	localparam int FIFO_DEPTH = 4;
	typedef struct packed {
		logic [12:0] addr;
		logic [7:0]  data;
	} seep_wr_t;
endpackage

// ### seep_master.sv
// SPI mode 0 master model that drives the EEPROM pins for the bench tasks.
// Assumes a 50 ns bench clock; one 400 ns serial clock is eight of its cycles.
`timescale 1ns/1ns
module seep_master (
	input  wire logic clock,  // Bench clock.
	input  wire logic so,     // Serial data from the device.
	input  wire logic so_oe,  // High while the device drives so.
	output logic      cs_n,   // Chip select, active low.
	output logic      sck,    // Serial clock, low between frames.
	output logic      si,     // Serial data to the device.
	output logic      oe_seen // Device drove so during this frame.
);
	// ****************************************************************
	// Frame driver
	// ****************************************************************
	logic idle = 1'b1;

	// Pins start deselected with the clock parked low.
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		oe_seen = 1'b0;
	end

	// Si toggles outside frames, so a stale level can never pass for data.
	always @(posedge clock) begin
		if (idle)
			si <= #1 ~si;
		if (!cs_n && so_oe === 1'b1)
			oe_seen <= 1'b1;
	end

	// Lowers select; the serial clock stays low until the first bit.
	task automatic start();
		idle = 1'b0;
		oe_seen = 1'b0;
		cs_n = 1'b0;
		repeat (4) @(posedge clock);
		#1;
	endtask

	// Low time of five cycles, high time of three; si moves well clear of the rise.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			repeat (2) @(posedge clock);
			#1;
			si = tx[i];
			repeat (3) @(posedge clock);
			#1;
			rx[i] = so_oe === 1'b1 ? so : ~so; // A released line reads as the wrong level.
			sck = 1'b1;
			repeat (3) @(posedge clock);
			#1;
			sck = 1'b0;
		end
	endtask

	// Select rises in the low time right after the last bit of a byte.
	task automatic finish();
		repeat (2) @(posedge clock);
		#1;
		cs_n = 1'b1;
		idle = 1'b1;
		repeat (8) @(posedge clock);
		#1;
	endtask
endmodule

// ### test_spi_eeprom_protect_rw.sv
// Self-checking bench for the serial EEPROM command block and its page buffer.
// Assumes seep_master drives the pins; programming time is cut to 500 cycles.
`timescale 1ns/1ns
module test_spi_eeprom_protect_rw;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	localparam int          PROG = 500;
	localparam logic [15:0] PROBE [4] = '{16'h0FFF, 16'h1000, 16'h17FF, 16'h1800};
	logic       clock = 1'b0;
	logic       reset = 1'b1;
	logic       wp_n = 1'b1;
	logic [2:0] nv_image = 3'h0;
	logic       cs_n, sck, si, so, so_oe, busy, oe_seen;
	logic [2:0] nv_status_out;
	logic [7:0] rx;
	logic [7:0] op3 = 8'h00;
	logic [7:0] got [8];
	logic [7:0] mem [4];
	int         num_errors = 0;
	int         check_count = 0;
	int         cycles = 0;
	int         t0;
	bit         prot;

	seep_top #(.PROG_CYCLES(PROG)) u_seep_top (
		.clock(clock), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
		.nv_status_in(nv_image), .so(so), .so_oe(so_oe), .busy(busy),
		.nv_status_out(nv_status_out));
	seep_master u_seep_master (.clock(clock), .so(so), .so_oe(so_oe), .cs_n(cs_n),
		.sck(sck), .si(si), .oe_seen(oe_seen));

	// Bench clock of 50 ns.
	always #25 clock = ~clock;

	// A hang is cut short well above the expected run length.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			num_errors++;
			stop_test();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		if (num_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic frame1(input logic [7:0] op);
		u_seep_master.start();
		u_seep_master.xfer(op, rx);
		u_seep_master.finish();
	endtask

	// Reads the status byte and compares it with the expected image.
	task automatic chk_st(input logic [7:0] exp);
		u_seep_master.start();
		u_seep_master.xfer(seep_pkg::OPC_STATUS_READ_CMD | op3, rx);
		u_seep_master.xfer(8'hA5, rx);
		u_seep_master.finish();
		check(rx, exp);
	endtask

	// Polls busy under a bound; a flag still high at the bound fails the test at once.
	task automatic wait_ready();
		for (int i = 0; i < 4 * PROG && busy !== 1'b0; i++) begin
			@(posedge clock);
			#1;
		end
		// A flag that never drops is a failure in its own right.
		if (busy !== 1'b0) begin
			num_errors++;
			stop_test();
		end
	endtask

	task automatic send_addr(input logic [7:0] op, input logic [15:0] a);
		u_seep_master.start();
		u_seep_master.xfer(op | op3, rx);
		u_seep_master.xfer(a[15:8], rx);
		u_seep_master.xfer(a[7:0], rx);
	endtask

	// Busy must stay low until select rises at the end of the data.
	task automatic wr_mem(input logic [15:0] a, input logic [7:0] d, input int n, input bit en);
		if (en)
			frame1(seep_pkg::OPC_WRITE_ENABLE_CMD | op3);
		send_addr(seep_pkg::OPC_WRITE, a);
		for (int i = 0; i < n; i++)
			u_seep_master.xfer(8'(d + i), rx);
		check({7'h0, busy}, 8'h00);
		u_seep_master.finish();
	endtask

	task automatic rd_mem(input logic [15:0] a, input int n);
		send_addr(seep_pkg::OPC_READ, a);
		for (int i = 0; i < n; i++)
			u_seep_master.xfer(8'hA5, got[i]);
		u_seep_master.finish();
	endtask

	// A trailing disable keeps the enable flag known after a refused write.
	task automatic wr_st(input logic [7:0] v);
		frame1(seep_pkg::OPC_WRITE_ENABLE_CMD | op3);
		u_seep_master.start();
		u_seep_master.xfer(seep_pkg::OPC_STATUS_WRITE_CMD | op3, rx);
		u_seep_master.xfer(v, rx);
		u_seep_master.finish();
		wait_ready();
		frame1(seep_pkg::OPC_WRITE_DISABLE_CMD | op3);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (16) @(posedge clock);
		#1;
		reset = 1'b0;
		repeat (8) @(posedge clock);
		#1;
		chk_st(8'h00);
		for (int b = 0; b < 2; b++) begin
			op3 = b ? 8'h08 : 8'h00;
			frame1(seep_pkg::OPC_WRITE_ENABLE_CMD | op3);
			chk_st(8'h02);
			frame1(seep_pkg::OPC_WRITE_DISABLE_CMD | op3);
			chk_st(8'h00);
		end
		op3 = 8'h00;
		wr_mem(16'h001E, 8'hC0, 3, 1'b1);
		t0 = cycles;
		check({7'h0, busy}, 8'h01);
		chk_st(8'hFF);
		frame1(seep_pkg::OPC_WRITE_ENABLE_CMD);
		wait_ready();
		check(8'(cycles - t0 > PROG - 20 && cycles - t0 <= PROG + 2), 8'h01);
		chk_st(8'h00);
		rd_mem(16'h001E, 2);
		check(got[0], 8'hC0);
		check(got[1], 8'hC1);
		check({7'h0, oe_seen}, 8'h01);
		rd_mem(16'hE000, 1);
		check(got[0], 8'hC2);
		wr_mem(16'h1FFF, 8'h5A, 1, 1'b1);
		wait_ready();
		rd_mem(16'h1FFF, 2);
		check(got[0], 8'h5A);
		check(got[1], 8'hC2);
		// Five bytes into a four-word buffer: the fifth is dropped.
		wr_mem(16'h0064, 8'h77, 1, 1'b1);
		wait_ready();
		wr_mem(16'h0060, 8'h30, 5, 1'b1);
		wait_ready();
		rd_mem(16'h0060, 5);
		for (int i = 0; i < 4; i++)
			check(got[i], 8'(8'h30 + i));
		check(got[4], 8'h77);
		op3 = 8'h08;
		for (int k = 0; k < 4; k++) begin
			wr_mem(PROBE[k], 8'h11, 1, 1'b1);
			wait_ready();
			mem[k] = 8'h11;
		end
		for (int bp = 1; bp < 4; bp++) begin
			wr_st(8'(bp << 2));
			chk_st(8'(bp << 2));
			check({5'h0, nv_status_out}, 8'(bp));
			for (int k = 0; k < 4; k++) begin
				wr_mem(PROBE[k], 8'(8'h20 + bp), 1, 1'b1);
				wait_ready();
				prot = bp == 3 || (bp == 2 && k > 0) || (bp == 1 && k == 3);
				if (!prot)
					mem[k] = 8'(8'h20 + bp);
				rd_mem(PROBE[k], 1);
				check(got[0], mem[k]);
			end
		end
		wr_st(8'h80);
		chk_st(8'h80);
		wp_n = 1'b0;
		wr_st(8'h8C);
		chk_st(8'h80);
		wr_st(8'h00);
		chk_st(8'h80);
		wr_mem(PROBE[0], 8'h66, 1, 1'b1);
		wait_ready();
		rd_mem(PROBE[0], 1);
		check(got[0], 8'h66);
		wp_n = 1'b1;
		wr_st(8'h00);
		chk_st(8'h00);
		wp_n = 1'b0;
		wr_st(8'h08);
		chk_st(8'h08);
		wr_mem(PROBE[0], 8'h99, 1, 1'b0);
		check({7'h0, busy}, 8'h00);
		rd_mem(PROBE[0], 1);
		check(got[0], 8'h66);
		send_addr(8'hFF, 16'h0000);
		u_seep_master.xfer(8'h00, rx);
		u_seep_master.finish();
		check({7'h0, oe_seen}, 8'h00);
		chk_st(8'h08);
		// A second reset reloads the stored protect image and clears write enable.
		nv_image = 3'h5;
		frame1(seep_pkg::OPC_WRITE_ENABLE_CMD);
		reset = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		reset = 1'b0;
		repeat (8) @(posedge clock);
		#1;
		check({5'h0, nv_status_out}, 8'h05);
		chk_st(8'h84);
		// With the pin high only the missing write enable can refuse a status write.
		wp_n = 1'b1;
		u_seep_master.start();
		u_seep_master.xfer(seep_pkg::OPC_STATUS_WRITE_CMD, rx);
		u_seep_master.xfer(8'h00, rx);
		u_seep_master.finish();
		check({7'h0, busy}, 8'h00);
		chk_st(8'h84);
		stop_test();
	end
endmodule
